//--- hdl/i2csw_pkg.sv
// constants, types and states shared by the four-channel switch
package i2csw_pkg;

  // clock and input filter timing
  localparam int MCLK_KHZ = 125000;
  localparam int SPIKE_NS = 50;
  // spikes up to this width are rejected, so round up
  localparam int FILT_CYC = (SPIKE_NS * MCLK_KHZ + 999999) / 1000000;

  // widths
  localparam int CHAN_NUM = 4;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_HI_BITS = 5;

  // bit counter values
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_BYTE = 4'h8;

  // reset values
  localparam logic [3:0] CHAN_RESET = 4'h0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  // fixed upper address bits; the value is arbitrary
  localparam logic [4:0] ADDR_HI_DEFAULT = 5'h1C;

  // synchronised pin bundle, idle value is all ones
  typedef struct packed {
    logic reset_n;
    logic addr_high;
    logic addr_low;
    logic [3:0] irq_n;
    logic sda;
    logic scl;
  } i2csw_pins_t;

  localparam int PINS_W = $bits(i2csw_pins_t);
  // fill every bit, the four interrupt bits included, so no false interrupt follows reset
  localparam i2csw_pins_t PINS_IDLE = '1;

  // bus protocol states
  typedef enum logic [2:0] {
    I2CSW_IDLE = 3'b000,
    I2CSW_ADDR = 3'b001,
    I2CSW_ADDR_ACK = 3'b010,
    I2CSW_WRITE = 3'b011,
    I2CSW_WRITE_ACK = 3'b100,
    I2CSW_READ = 3'b101,
    I2CSW_READ_ACK = 3'b110,
    I2CSW_IGNORE = 3'b111
  } i2csw_state_t;

endpackage : i2csw_pkg

//--- hdl/i2csw_sync_filter.sv
// two-stage synchroniser with spike filter for each asynchronous pin
`timescale 1ns/1ps
module i2csw_sync_filter #(
  parameter int WIDTH = 9,
  parameter int FILT_CYC = 7,
  parameter logic [WIDTH-1:0] IDLE_VAL = '1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // raw pins and filtered levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYC - 1);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_reg;
      logic sync_reg;
      logic [CW-1:0] cnt_reg;

      // plain two flip-flop synchroniser, first stage read only by the second
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          meta_reg <= IDLE_VAL[i];
          sync_reg <= IDLE_VAL[i];
        end
        else
        begin
          meta_reg <= pin_in[i];
          sync_reg <= meta_reg;
        end
      end

      // a new level must persist for the full spike window before it is taken
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          cnt_reg <= '0;
          pin_out[i] <= IDLE_VAL[i];
        end
        else if (sync_reg == pin_out[i])
          cnt_reg <= '0;
        else if (cnt_reg == CNT_LAST)
        begin
          cnt_reg <= '0;
          pin_out[i] <= sync_reg;
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
    end
  endgenerate

endmodule : i2csw_sync_filter

//--- hdl/i2csw_top.sv
// bus target and channel select logic of the four-channel switch
//
// Behaviour
// R1 - One upstream clock and data pair is routed to up to four downstream channels.
// R2 - Any single channel or any mix of channels may be connected as the control byte says.
// R3 - Four active-low interrupt inputs exist, one per downstream channel.
// R4 - The interrupt output is the AND of the four active-low inputs, low when any is low.
// R5 - Holding the reset pin low sends the bus machine idle and disconnects every channel.
// R6 - Power-on reset does the same as the reset pin.
// R7 - Two address pins form the low address bits so four switches can share one bus.
// R8 - Bus clocks from zero up to 400 kHz work, and the master stays within that rate.
// R9 - Control bits 3 to 0 enable channels 3 to 0 and bits 7 to 4 are ignored.
// R10 - A newly written selection takes effect only at the next STOP on the bus.
// R11 - Of several written bytes the last one is kept, and a read returns the selection.
// R12 - After reset the control value is all zeros, so no channel is selected.
// R13 - Each unselected channel stays isolated, shown as one enable output per channel.
`timescale 1ns/1ps
module i2csw_top #(
  parameter logic [4:0] ADDR_HI = i2csw_pkg::ADDR_HI_DEFAULT
) (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic rst,
  // upstream bus, data is open-drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // reset and address pins
  input wire logic reset_in_n,
  input wire logic addr_pin_low,
  input wire logic addr_pin_high,
  // downstream interrupts
  input wire logic chan0_irq_in_n,
  input wire logic chan1_irq_in_n,
  input wire logic chan2_irq_in_n,
  input wire logic chan3_irq_in_n,
  output logic irq_out_n,
  // downstream pass-gate enables
  output logic [3:0] chan_en
);

  i2csw_pkg::i2csw_pins_t raw_pins;
  i2csw_pkg::i2csw_pins_t pins;
  i2csw_pkg::i2csw_state_t state_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic soft_rst;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [3:0] pend_reg;
  logic pend_valid_reg;
  logic rw_reg;
  logic nack_reg;
  logic [6:0] my_addr;

  // gather the asynchronous pins into one bundle
  assign raw_pins.reset_n = reset_in_n;
  assign raw_pins.addr_high = addr_pin_high;
  assign raw_pins.addr_low = addr_pin_low;
  assign raw_pins.irq_n = {chan3_irq_in_n, chan2_irq_in_n, chan1_irq_in_n, chan0_irq_in_n}; // R3
  assign raw_pins.sda = sda_in;
  assign raw_pins.scl = scl_in;

  // every pin is synchronised and spike filtered before use
  i2csw_sync_filter #(
    .WIDTH(i2csw_pkg::PINS_W),
    .FILT_CYC(i2csw_pkg::FILT_CYC),
    .IDLE_VAL(i2csw_pkg::PINS_IDLE)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in(raw_pins),
    .pin_out(pins)
  );

  // the pin reset acts through the synchroniser, so it needs a few cycles low
  assign soft_rst = ~pins.reset_n; // R5
  assign my_addr = {ADDR_HI, pins.addr_high, pins.addr_low}; // R7

  // bus events; 125 MHz oversampling covers the full 0 to 400 kHz range
  assign scl_rise = pins.scl & ~scl_d_reg; // R8
  assign scl_fall = ~pins.scl & scl_d_reg;
  assign start_cond = scl_d_reg & pins.scl & sda_d_reg & ~pins.sda;
  assign stop_cond = scl_d_reg & pins.scl & ~sda_d_reg & pins.sda;

  // delayed copies for edge detection
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= pins.scl;
      sda_d_reg <= pins.sda;
    end
  end

  // interrupt output is a registered wired-AND of the inputs
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      irq_out_n <= 1'b1;
    else
      irq_out_n <= &pins.irq_n; // R4
  end

  // the switch itself never drives data high
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // bus protocol state, bit counter and shifter
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst) // R6
    begin
      state_reg <= i2csw_pkg::I2CSW_IDLE;
      bit_cnt_reg <= i2csw_pkg::BIT_CNT_ZERO;
      shift_reg <= i2csw_pkg::SHIFT_RESET;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (soft_rst) // R5
    begin
      state_reg <= i2csw_pkg::I2CSW_IDLE;
      bit_cnt_reg <= i2csw_pkg::BIT_CNT_ZERO;
      sda_oe <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_reg <= i2csw_pkg::I2CSW_IDLE;
      sda_oe <= 1'b0;
    end
    else if (start_cond)
    begin
      // a repeated start also lands here
      state_reg <= i2csw_pkg::I2CSW_ADDR;
      bit_cnt_reg <= i2csw_pkg::BIT_CNT_ZERO;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state_reg)
        i2csw_pkg::I2CSW_ADDR, i2csw_pkg::I2CSW_WRITE:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], pins.sda};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end
          else if (scl_fall && bit_cnt_reg == i2csw_pkg::BIT_CNT_BYTE)
          begin
            bit_cnt_reg <= i2csw_pkg::BIT_CNT_ZERO;
            if (state_reg == i2csw_pkg::I2CSW_WRITE)
            begin
              sda_oe <= 1'b1;
              state_reg <= i2csw_pkg::I2CSW_WRITE_ACK;
            end
            else if (shift_reg[7:1] == my_addr) // R7
            begin
              rw_reg <= shift_reg[0];
              sda_oe <= 1'b1;
              state_reg <= i2csw_pkg::I2CSW_ADDR_ACK;
            end
            else
              state_reg <= i2csw_pkg::I2CSW_IGNORE;
          end
        end
        i2csw_pkg::I2CSW_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw_reg)
            begin
              // read byte is {0000, selection}; its msb is zero, so the first bit pulls low
              shift_reg <= {3'h0, chan_en, 1'b0}; // R11
              sda_oe <= 1'b1;
              bit_cnt_reg <= i2csw_pkg::BIT_CNT_ZERO;
              state_reg <= i2csw_pkg::I2CSW_READ;
            end
            else
            begin
              sda_oe <= 1'b0;
              state_reg <= i2csw_pkg::I2CSW_WRITE;
            end
          end
        end
        i2csw_pkg::I2CSW_WRITE_ACK:
        begin
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            state_reg <= i2csw_pkg::I2CSW_WRITE;
          end
        end
        i2csw_pkg::I2CSW_READ:
        begin
          if (scl_rise)
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          else if (scl_fall)
          begin
            if (bit_cnt_reg == i2csw_pkg::BIT_CNT_BYTE)
            begin
              sda_oe <= 1'b0;
              state_reg <= i2csw_pkg::I2CSW_READ_ACK;
            end
            else
            begin
              // open-drain: drive only for a zero bit
              sda_oe <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        i2csw_pkg::I2CSW_READ_ACK:
        begin
          if (scl_rise)
            nack_reg <= pins.sda;
          else if (scl_fall)
          begin
            bit_cnt_reg <= i2csw_pkg::BIT_CNT_ZERO;
            if (nack_reg)
              state_reg <= i2csw_pkg::I2CSW_IGNORE;
            else
            begin
              shift_reg <= {3'h0, chan_en, 1'b0}; // R11
              sda_oe <= 1'b1;
              state_reg <= i2csw_pkg::I2CSW_READ;
            end
          end
        end
        i2csw_pkg::I2CSW_IDLE, i2csw_pkg::I2CSW_IGNORE:
          sda_oe <= 1'b0;
        default:
        begin
          sda_oe <= 1'b0;
          state_reg <= i2csw_pkg::I2CSW_IDLE;
        end
      endcase
    end
  end

  // pending selection; each new byte overwrites the last
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pend_reg <= i2csw_pkg::CHAN_RESET;
      pend_valid_reg <= 1'b0;
    end
    else if (soft_rst)
    begin
      pend_reg <= i2csw_pkg::CHAN_RESET;
      pend_valid_reg <= 1'b0;
    end
    else if (stop_cond)
      pend_valid_reg <= 1'b0;
    else if (state_reg == i2csw_pkg::I2CSW_WRITE && scl_fall &&
             bit_cnt_reg == i2csw_pkg::BIT_CNT_BYTE)
    begin
      pend_reg <= shift_reg[3:0]; // R9 R11
      pend_valid_reg <= 1'b1;
    end
  end

  // active selection drives one pass-gate enable per channel
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      chan_en <= i2csw_pkg::CTRL_RESET[3:0]; // R12 R6
    else if (soft_rst)
      chan_en <= i2csw_pkg::CTRL_RESET[3:0]; // R5
    else if (stop_cond && pend_valid_reg)
      chan_en <= pend_reg; // R10 R2 R1 R13
  end

endmodule : i2csw_top

//--- bench/i2csw_top_monitor.sv
// port checker for the switch top level
`timescale 1ns/1ps
module i2csw_top_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // upstream bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // pins and outputs
  input wire logic reset_in_n,
  input wire logic chan0_irq_in_n,
  input wire logic chan1_irq_in_n,
  input wire logic chan2_irq_in_n,
  input wire logic chan3_irq_in_n,
  input wire logic irq_out_n,
  input wire logic [3:0] chan_en
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // all four interrupt inputs combined
  wire logic irq_all = chan0_irq_in_n & chan1_irq_in_n & chan2_irq_in_n & chan3_irq_in_n;
  // 16 cycles outlast the pin filters with margin
  sequence irq_low_s;
    !irq_all [*8] ##1 !irq_all [*8];
  endsequence
  sequence irq_high_s;
    irq_all [*8] ##1 irq_all [*8];
  endsequence
  sequence pin_low_s;
    !reset_in_n [*8] ##1 !reset_in_n [*8];
  endsequence
  rst_clear_a: assert property (disable iff (1'h0)
    rst |-> chan_en == 4'h0 && !sda_oe && irq_out_n) else $error("reset left outputs on");
  irq_low_a: assert property (irq_low_s |-> !irq_out_n)
    else $error("irq output high");
  irq_high_a: assert property (irq_high_s |-> irq_out_n)
    else $error("irq output low");
  pin_reset_a: assert property (pin_low_s |-> chan_en == 4'h0 && !sda_oe)
    else $error("reset pin ignored");
  chan_quiet_a: assert property ($changed(chan_en) |-> scl_in && sda_in)
    else $error("channels moved on a busy bus");
  ack_rise_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pulled while clock high");
  ack_fall_a: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data freed while clock high");
  sda_low_a: assert property (sda_oe |-> sda_out == 1'h0)
    else $error("data driven high");
endmodule : i2csw_top_monitor

bind i2csw_top i2csw_top_monitor i2csw_top_monitor_inst (.mclk(mclk), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .reset_in_n(reset_in_n), .chan0_irq_in_n(chan0_irq_in_n), .chan1_irq_in_n(chan1_irq_in_n),
  .chan2_irq_in_n(chan2_irq_in_n), .chan3_irq_in_n(chan3_irq_in_n),
  .irq_out_n(irq_out_n), .chan_en(chan_en));

//--- bench/i2csw_master.sv
// upstream bus master model for the switch
`timescale 1ns/1ps
module i2csw_master (
  // clock
  input wire logic mclk,
  // resolved data line
  input wire logic bus_sda,
  // open-drain drives, high means released
  output logic scl,
  output logic sda
);
  // low phase; 20 + 180 + 120 cycles keeps the bus under 400 kHz
  int lo_cyc = 180;
  initial
  begin
    scl = 1'h1;
    sda = 1'h1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt
  // start when s is high, stop when low; the start gap also gives bus free time
  task automatic cond(input logic s);
    wt(20);
    sda = s;
    wt(lo_cyc);
    scl = 1'h1;
    wt(120);
    sda = ~s;
    wt(120);
    scl = ~s;
  endtask : cond
  // nine slots, msb first; data moves early in the low phase, 20 cycles after the clock falls, so no false start shows
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--)
    begin
      wt(20);
      sda = o[k];
      wt(lo_cyc);
      scl = 1'h1;
      wt(120);
      i[k] = bus_sda;
      scl = 1'h0;
    end
  endtask : xfer
endmodule : i2csw_master

//--- bench/i2csw_top_tb.sv
// self-checking bench for the switch: writes, reads, resets, interrupts
`timescale 1ns/1ps
module i2csw_top_tb;
  logic mclk;
  logic rst = 1'h0;
  logic reset_in_n = 1'h1;
  logic [1:0] apin = 2'h0;
  logic [3:0] irq_n = 4'hF;
  logic sda_out, sda_oe, irq_out_n, m_scl, m_sda;
  logic [3:0] chan_en;
  logic [3:0] cur = 4'h0;
  logic [3:0] last_en = 4'h0;
  logic [3:0] exp_q[$];
  logic [8:0] rsp;
  logic [31:0] r;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 16;
  // open-drain data line with pull-up
  wire logic bus_sda = m_sda & (sda_oe ? sda_out : 1'h1);
  initial
  begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  i2csw_master i2csw_master_inst (.mclk(mclk), .bus_sda(bus_sda), .scl(m_scl), .sda(m_sda));
  i2csw_top i2csw_top_inst (.mclk(mclk), .rst(rst), .scl_in(m_scl), .sda_in(bus_sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .reset_in_n(reset_in_n), .addr_pin_low(apin[0]),
    .addr_pin_high(apin[1]), .chan0_irq_in_n(irq_n[0]), .chan1_irq_in_n(irq_n[1]),
    .chan2_irq_in_n(irq_n[2]), .chan3_irq_in_n(irq_n[3]), .irq_out_n(irq_out_n),
    .chan_en(chan_en));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // address then two bytes; a match acks and only the last byte counts, at the stop
  task automatic wr(input logic [6:0] a, input logic [7:0] b0, input logic [7:0] b1);
    logic ok;
    ok = (a == {i2csw_pkg::ADDR_HI_DEFAULT, apin});
    i2csw_master_inst.cond(1'h1);
    i2csw_master_inst.xfer({a, 2'h1}, rsp);
    chk("ack", {7'h0, ok}, {7'h0, ~rsp[0]});
    if (ok)
    begin
      i2csw_master_inst.xfer({b0, 1'h1}, rsp);
      i2csw_master_inst.xfer({b1, 1'h1}, rsp);
      chk("chan_en", {4'h0, cur}, {4'h0, chan_en});
      if (b1[3:0] != cur)
        exp_q.push_back(b1[3:0]);
      cur = b1[3:0];
    end
    i2csw_master_inst.cond(1'h0);
  endtask : wr
  // read the selection back n times, acking all but the last; interrupt output checked too
  task automatic rd(input int n = 1);
    i2csw_master_inst.cond(1'h1);
    i2csw_master_inst.xfer({i2csw_pkg::ADDR_HI_DEFAULT, apin, 2'h3}, rsp);
    for (int j = n; j > 0; j--)
    begin
      i2csw_master_inst.xfer({8'hFF, j == 1}, rsp);
      chk("read", {4'h0, cur}, rsp[8:1]);
    end
    chk("irq_out_n", {7'h0, &irq_n}, {7'h0, irq_out_n});
    i2csw_master_inst.cond(1'h0);
  endtask : rd
  // pin reset held past the filter, or power-on reset; channels must drop
  task automatic rs(input logic pin);
    if (cur != 4'h0)
      exp_q.push_back(4'h0);
    cur = 4'h0;
    reset_in_n = ~pin;
    rst = ~pin;
    repeat (20) @(negedge mclk);
    reset_in_n = 1'h1;
    rst = 1'h0;
    repeat (15) @(negedge mclk);
  endtask : rs
  // result side: each change of the enables takes the oldest note
  always @(negedge mclk)
  begin
    if (chan_en !== last_en)
    begin
      chk("chan_en", {4'h0, ((exp_q.size() > 0) ? exp_q.pop_front() : last_en)}, {4'h0, chan_en});
      last_en = chan_en;
    end
  end
  // hang guard: the run needs about 89,000 cycles, the guard fires at 95,000
  initial
  begin
    #760000;
    miscompares++;
    close_out();
  end
  initial
  begin
    // raised after time zero so the asynchronous reset branches see an edge
    #1 rst = 1'h1;
    repeat (3) @(negedge mclk);
    rst = 1'h0;
    repeat (12) @(negedge mclk);
    rd();
    // one channel each pass, random ignored bits and pins, one slow pass
    for (int k = 0; k < 4; k++)
    begin
      r = $random(seed);
      apin = r[17:16];
      irq_n = r[23:20];
      i2csw_master_inst.lo_cyc = (k == 2) ? 360 : 180;
      repeat (20) @(negedge mclk);
      wr({i2csw_pkg::ADDR_HI_DEFAULT, apin}, r[7:0], {r[15:12], 4'h1 << k});
      if (k[0])
        rd(2);
    end
    wr({i2csw_pkg::ADDR_HI_DEFAULT, ~apin}, 8'hFF, 8'hFF);
    rs(1'h0);
    rd();
    wr({i2csw_pkg::ADDR_HI_DEFAULT, apin}, 8'h00, 8'hFF);
    rs(1'h1);
    chk("queue", 8'h0, 8'(exp_q.size()));
    close_out();
  end
endmodule : i2csw_top_tb
